/* File: rtl/rxf_pkg.sv */
// Constants and types for the radio receive byte buffer
package rxf_pkg;
    // ==========================================================
    // Buffer geometry
    localparam logic [6:0] FIFO_DEPTH   = 7'h40;
    localparam logic [5:0] PTR_RST      = 6'h00;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CMD      = 8'h00;
    localparam logic [7:0] OFS_IOCFG    = 8'h04;
    localparam logic [7:0] OFS_PLEN     = 8'h08;
    localparam logic [7:0] OFS_PCTL1ST  = 8'h0c;
    localparam logic [7:0] OFS_PCTL2ND  = 8'h10;
    localparam logic [7:0] OFS_DATA     = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;
    // ==========================================================
    // Command register bits (write only, self clearing)
    localparam int         CMD_IDLE     = 0;
    localparam int         CMD_FLUSH    = 1;
    localparam int         CMD_RX       = 2;
    // ==========================================================
    // Packet control fields
    localparam int         LEN_CFG_LSB  = 0;
    localparam int         CRC_EN_BIT   = 2;
    localparam int         APPEND_BIT   = 2;
    localparam logic [1:0] LEN_FIXED    = 2'h0;
    localparam logic [1:0] LEN_VARIABLE = 2'h1;
    // ==========================================================
    // Status register fields
    localparam int         ST_CNT_LSB   = 0;
    localparam int         ST_PF_BIT    = 8;
    localparam int         ST_STATE_LSB = 9;
    localparam int         ST_VAR_BIT   = 11;
    // ==========================================================
    // Status output selection codes and reset values
    localparam logic [5:0] SEL_NONEMPTY = 6'h01;
    localparam logic [5:0] SEL_RX_OK    = 6'h06;
    localparam logic [5:0] SEL_RST      = 6'h06;
    localparam logic [7:0] PLEN_RST     = 8'hff;
    // ==========================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RX,
        ST_OVERFLOW
    } rxf_state_type;

    typedef struct packed {
        logic [63:0][7:0] mem;
        logic [5:0]       wp;
        logic [5:0]       rp;
        logic [6:0]       cnt;
        logic             pf_v;
        logic [7:0]       pf_d;
        rxf_state_type    st;
        logic [5:0]       cfg_sel;
        logic [7:0]       plen;
        logic [2:0]       pctl1st;
        logic [2:0]       pctl2nd;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       waddr;
        logic [31:0]      wdata;
        logic             wbe;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic             gso;
    } rxf_regs_type;
endpackage

/* File: rtl/rxf_radio_rx_fifo.sv */
// Radio receive byte buffer with prefetch stage and AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the address map.

// Function
// - 64-byte buffer plus one-byte prefetch stage
// - Byte beyond 65 unread enters overflow state
// - Code 0x06 status output drops on overflow
// - Length field: 1 variable, 0 fixed
// - Append in second, CRC in first control
module rxf_radio_rx_fifo (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // Radio core byte stream
    input  wire logic        i_rx_valid,
    input  wire logic [7:0]  i_rx_data,
    // General status output
    output logic             o_general_status_output,
    // AXI4-Lite write channels
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic [1:0]       o_bresp,
    // AXI4-Lite read channels
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [7:0]  i_araddr,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp
);

    rxf_pkg::rxf_regs_type r;
    rxf_pkg::rxf_regs_type next_r;
    logic                  idle_go;
    logic                  flush_go;
    logic                  rx_go;
    logic                  wr_go;
    logic                  pop;
    logic                  move;

    // ==========================================================
    // Status output selection
    function automatic logic gso_of(input logic [5:0] sel,
                                    input rxf_pkg::rxf_state_type st,
                                    input logic [6:0] cnt);
        logic v;
        v = 1'b0;
        case (sel)
            rxf_pkg::SEL_RX_OK:    v = (st == rxf_pkg::ST_RX);
            rxf_pkg::SEL_NONEMPTY: v = (cnt != 7'h00);
            default:               v = 1'b0;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        next_r   = r;
        idle_go  = 1'b0;
        flush_go = 1'b0;
        rx_go    = 1'b0;
        pop      = 1'b0;
        move     = 1'b0;

        // Address and data are taken in either order
        if (i_awvalid && r.awready) begin
            next_r.aw_got = 1'b1;
            next_r.waddr  = i_awaddr;
        end
        if (i_wvalid && r.wready) begin
            next_r.w_got = 1'b1;
            next_r.wdata = i_wdata;
            next_r.wbe   = i_wstrb[0];
        end
        if (r.bvalid && i_bready) begin
            next_r.bvalid = 1'b0;
        end
        wr_go = r.aw_got && r.w_got && !r.bvalid;
        if (wr_go) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = rxf_pkg::RESP_OKAY;
            case (r.waddr)
                rxf_pkg::OFS_CMD: begin
                    idle_go  = r.wbe && r.wdata[rxf_pkg::CMD_IDLE];
                    flush_go = r.wbe && r.wdata[rxf_pkg::CMD_FLUSH];
                    rx_go    = r.wbe && r.wdata[rxf_pkg::CMD_RX];
                end
                rxf_pkg::OFS_IOCFG: begin
                    if (r.wbe) begin
                        next_r.cfg_sel = r.wdata[5:0];
                    end
                end
                rxf_pkg::OFS_PLEN: begin
                    if (r.wbe) begin
                        next_r.plen = r.wdata[7:0];
                    end
                end
                rxf_pkg::OFS_PCTL1ST: begin
                    if (r.wbe) begin
                        next_r.pctl1st = r.wdata[2:0];
                    end
                end
                rxf_pkg::OFS_PCTL2ND: begin
                    if (r.wbe) begin
                        next_r.pctl2nd = r.wdata[2:0];
                    end
                end
                rxf_pkg::OFS_DATA, rxf_pkg::OFS_STATUS: begin
                    next_r.bresp = rxf_pkg::RESP_OKAY;
                end
                default: next_r.bresp = rxf_pkg::RESP_SLVERR;
            endcase
        end
        next_r.awready = !next_r.aw_got && !next_r.bvalid;
        next_r.wready  = !next_r.w_got && !next_r.bvalid;

        // Read channel; a data read of a non-empty buffer pops one byte
        if (r.rvalid && i_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (i_arvalid && r.arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = rxf_pkg::RESP_OKAY;
            next_r.rdata  = 32'h0000_0000;
            case (i_araddr)
                rxf_pkg::OFS_CMD: next_r.rdata = 32'h0000_0000;
                rxf_pkg::OFS_IOCFG: next_r.rdata[5:0] = r.cfg_sel;
                rxf_pkg::OFS_PLEN: next_r.rdata[7:0] = r.plen;
                rxf_pkg::OFS_PCTL1ST: next_r.rdata[2:0] = r.pctl1st;
                rxf_pkg::OFS_PCTL2ND: next_r.rdata[2:0] = r.pctl2nd;
                rxf_pkg::OFS_DATA: begin
                    // Empty buffer reads zero and pops nothing
                    if (r.cnt != 7'h00) begin
                        next_r.rdata[7:0] = r.mem[r.rp];
                        pop = 1'b1;
                    end
                end
                rxf_pkg::OFS_STATUS: begin
                    next_r.rdata[rxf_pkg::ST_CNT_LSB +: 7] = r.cnt;
                    next_r.rdata[rxf_pkg::ST_PF_BIT]       = r.pf_v;
                    next_r.rdata[rxf_pkg::ST_STATE_LSB +: 2] = r.st;
                    next_r.rdata[rxf_pkg::ST_VAR_BIT] =
                        (r.pctl1st[rxf_pkg::LEN_CFG_LSB +: 2]
                         == rxf_pkg::LEN_VARIABLE);
                end
                default: next_r.rresp = rxf_pkg::RESP_SLVERR;
            endcase
        end
        next_r.arready = !next_r.rvalid;

        // Radio state; overflow is left only through idle
        case (r.st)
            rxf_pkg::ST_IDLE: begin
                if (rx_go) begin
                    next_r.st = rxf_pkg::ST_RX;
                end
            end
            rxf_pkg::ST_RX, rxf_pkg::ST_OVERFLOW: begin
                if (idle_go) begin
                    next_r.st = rxf_pkg::ST_IDLE;
                end
            end
            default: next_r.st = rxf_pkg::ST_IDLE;
        endcase

        // Drain side
        if (pop) begin
            next_r.rp = r.rp + 6'h01;
        end
        // Prefetch stage moves into storage when there is room
        if (r.pf_v && (r.cnt < rxf_pkg::FIFO_DEPTH || pop)) begin
            move = 1'b1;
            next_r.mem[r.wp] = r.pf_d;
            next_r.wp        = r.wp + 6'h01;
            next_r.pf_v      = 1'b0;
        end
        case ({move, pop})
            2'b10:   next_r.cnt = r.cnt + 7'h01;
            2'b01:   next_r.cnt = r.cnt - 7'h01;
            default: next_r.cnt = r.cnt;
        endcase
        // Radio side; a byte with nowhere to go is lost
        if (r.st == rxf_pkg::ST_RX && i_rx_valid && !idle_go) begin
            if (!next_r.pf_v) begin
                next_r.pf_v = 1'b1;
                next_r.pf_d = i_rx_data;
            end else begin
                next_r.st = rxf_pkg::ST_OVERFLOW;
            end
        end
        // Flush only from idle, so idle must come first
        if (flush_go && r.st == rxf_pkg::ST_IDLE) begin
            next_r.cnt  = 7'h00;
            next_r.wp   = rxf_pkg::PTR_RST;
            next_r.rp   = rxf_pkg::PTR_RST;
            next_r.pf_v = 1'b0;
        end

        next_r.gso = gso_of(next_r.cfg_sel, next_r.st, next_r.cnt);
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            r         <= '0;
            r.cfg_sel <= rxf_pkg::SEL_RST;
            r.plen    <= rxf_pkg::PLEN_RST;
        end else begin
            r <= next_r;
        end
    end

    assign o_general_status_output = r.gso;
    assign o_awready               = r.awready;
    assign o_wready                = r.wready;
    assign o_bvalid                = r.bvalid;
    assign o_bresp                 = r.bresp;
    assign o_arready               = r.arready;
    assign o_rvalid                = r.rvalid;
    assign o_rdata                 = r.rdata;
    assign o_rresp                 = r.rresp;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_storage_full;
        r.pf_v && r.cnt == rxf_pkg::FIFO_DEPTH;
    endsequence

    sequence s_emptied;
        r.cnt == 7'h00 && !r.pf_v && r.st == rxf_pkg::ST_IDLE;
    endsequence

    property p_depth;
        r.cnt <= rxf_pkg::FIFO_DEPTH;
    endproperty
    a_depth: assert property (p_depth)
        else $error("buffer count above depth");

    property p_prefetch_take;
        (r.st == rxf_pkg::ST_RX && i_rx_valid && !idle_go && !r.pf_v)
            |=> r.pf_v;
    endproperty
    a_prefetch_take: assert property (p_prefetch_take)
        else $error("radio byte not taken by prefetch");

    property p_ovf_entry;
        $rose(r.st == rxf_pkg::ST_OVERFLOW) |-> $past(r.pf_v)
            && $past(r.cnt) == rxf_pkg::FIFO_DEPTH;
    endproperty
    a_ovf_entry: assert property (p_ovf_entry)
        else $error("overflow without full storage");

    property p_ovf_when_full;
        (s_storage_full ##0 (r.st == rxf_pkg::ST_RX && i_rx_valid
            && !idle_go && !pop)) |=> r.st == rxf_pkg::ST_OVERFLOW;
    endproperty
    a_ovf_when_full: assert property (p_ovf_when_full)
        else $error("full storage did not overflow");

    property p_gso_ovf;
        (r.st == rxf_pkg::ST_OVERFLOW && r.cfg_sel == rxf_pkg::SEL_RX_OK)
            |-> !o_general_status_output;
    endproperty
    a_gso_ovf: assert property (p_gso_ovf)
        else $error("status output high in overflow");

    property p_stuck;
        (r.st == rxf_pkg::ST_OVERFLOW && !idle_go)
            |=> r.st == rxf_pkg::ST_OVERFLOW;
    endproperty
    a_stuck: assert property (p_stuck)
        else $error("overflow left without idle strobe");

    property p_flush;
        (flush_go && r.st == rxf_pkg::ST_IDLE) |=> s_emptied;
    endproperty
    a_flush: assert property (p_flush)
        else $error("flush did not empty buffer");

    property p_bhold;
        (r.bvalid && !i_bready) |=> r.bvalid && $stable(r.bresp);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped early");

    property p_rhold;
        (r.rvalid && !i_rready) |=> r.rvalid && $stable(r.rdata);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data dropped early");

endmodule

/* File: test/rxf_host_model.sv */
// Host model: AXI4-Lite master plus receive buffer service routines
module rxf_host_model (
    // Clock
    input  wire logic        i_ref_clk,
    // Write channels
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic [7:0]       o_awaddr,
    output logic             o_wvalid,
    input  wire logic        i_wready,
    output logic [31:0]      o_wdata,
    output logic [3:0]       o_wstrb,
    input  wire logic        i_bvalid,
    output logic             o_bready,
    input  wire logic [1:0]  i_bresp,
    // Read channels
    output logic             o_arvalid,
    input  wire logic        i_arready,
    output logic [7:0]       o_araddr,
    input  wire logic        i_rvalid,
    output logic             o_rready,
    input  wire logic [31:0] i_rdata,
    input  wire logic [1:0]  i_rresp
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAIT_MAX = 50;
    // The bench may hold the answer's ready back a cycle, so the slave
    // is seen holding a response, and may clear the low byte strobe
    logic          late_ready = 1'b0;
    logic [3:0]    strb_sel   = 4'hf;
    initial begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
        {o_awaddr, o_araddr, o_wstrb} = 20'h00000;
        o_wdata = 32'h00000000;
    end
    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        int n;
        @(posedge i_ref_clk);
        o_awaddr  <= a;
        o_wdata   <= v;
        o_wstrb   <= strb_sel;
        o_awvalid <= 1'b1;
        o_wvalid  <= 1'b1;
        o_bready  <= !late_ready;
        for (n = 0; n < WAIT_MAX; n++) begin
            @(posedge i_ref_clk);
            // Released payload must not keep looking valid
            if (o_awvalid && i_awready === 1'b1) begin
                o_awvalid <= 1'b0;
                o_awaddr  <= ~o_awaddr;
            end
            if (o_wvalid && i_wready === 1'b1) begin
                o_wvalid <= 1'b0;
                o_wdata  <= ~o_wdata;
            end
            if (i_bvalid === 1'b1 && o_bready) break;
            if (i_bvalid === 1'b1) o_bready <= 1'b1;
        end
        resp = i_bresp;
        o_bready <= 1'b0;
        if (n >= WAIT_MAX) rxf_radio_rx_fifo_test.timeout_hit();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        int n;
        @(posedge i_ref_clk);
        o_araddr  <= a;
        o_arvalid <= 1'b1;
        o_rready  <= !late_ready;
        for (n = 0; n < WAIT_MAX; n++) begin
            @(posedge i_ref_clk);
            if (o_arvalid && i_arready === 1'b1) begin
                o_arvalid <= 1'b0;
                o_araddr  <= ~o_araddr;
            end
            if (i_rvalid === 1'b1 && o_rready) break;
            if (i_rvalid === 1'b1) o_rready <= 1'b1;
        end
        v = i_rdata;
        resp = i_rresp;
        o_rready <= 1'b0;
        if (n >= WAIT_MAX) rxf_radio_rx_fifo_test.timeout_hit();
    endtask
    // ==========================================================
    // Service routines
    // Flush is ignored until the radio is idle, so order matters
    task automatic recover();
        logic [1:0] r;
        wr(rxf_pkg::OFS_CMD, 32'h1 << rxf_pkg::CMD_IDLE, r);
        wr(rxf_pkg::OFS_CMD, 32'h1 << rxf_pkg::CMD_FLUSH, r);
    endtask
    // Length byte, payload and two status bytes fit the storage
    task automatic set_length(input logic var_mode);
        logic [1:0] r;
        wr(rxf_pkg::OFS_PLEN, var_mode ? 32'h3d : 32'h3e, r);
        wr(rxf_pkg::OFS_PCTL1ST, {31'h0, var_mode}, r);
    endtask
    task automatic drain_one(output logic [7:0] b);
        logic [31:0] v;
        logic [1:0]  r;
        rd(rxf_pkg::OFS_DATA, v, r);
        b = v[7:0];
    endtask
endmodule

/* File: test/rxf_radio_rx_fifo_test.sv */
// Self-checking bench for the radio receive byte buffer
`define CHECK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            failures++; \
            $display("unexpected %s: expected %h, seen %h", nm, e, g); \
        end \
    end
module rxf_radio_rx_fifo_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_ref_clk, i_sys_rst, i_rx_valid, o_general_status_output;
    logic [7:0]  i_rx_data, i_awaddr, i_araddr;
    logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid;
    logic        i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
    logic [31:0] i_wdata, o_rdata, d;
    logic [3:0]  i_wstrb;
    logic [1:0]  o_bresp, o_rresp, r;
    logic [7:0]  b;
    int          failures = 0;
    int          n_compared = 0;
    rxf_radio_rx_fifo rxf_radio_rx_fifo_inst (
        .i_ref_clk, .i_sys_rst, .i_rx_valid, .i_rx_data,
        .o_general_status_output, .i_awvalid, .o_awready, .i_awaddr,
        .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready,
        .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready,
        .o_rdata, .o_rresp);
    rxf_host_model rxf_host_model_inst (
        .i_ref_clk(i_ref_clk),
        .o_awvalid(i_awvalid), .i_awready(o_awready), .o_awaddr(i_awaddr),
        .o_wvalid(i_wvalid), .i_wready(o_wready), .o_wdata(i_wdata),
        .o_wstrb(i_wstrb), .i_bvalid(o_bvalid), .o_bready(i_bready),
        .i_bresp(o_bresp), .o_arvalid(i_arvalid), .i_arready(o_arready),
        .o_araddr(i_araddr), .i_rvalid(o_rvalid), .o_rready(i_rready),
        .i_rdata(o_rdata), .i_rresp(o_rresp));
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] st_word(input logic vm,
        input logic [1:0] s, input logic pf, input logic [6:0] c);
        return {20'h0, vm, s, pf, 1'b0, c};
    endfunction
    task automatic rd(input logic [7:0] a);
        rxf_host_model_inst.rd(a, d, r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        rxf_host_model_inst.wr(a, v, r);
    endtask
    task automatic send(input logic [7:0] v);
        @(posedge i_ref_clk);
        i_rx_valid <= 1'b1;
        i_rx_data  <= v;
        @(posedge i_ref_clk);
        i_rx_valid <= 1'b0;
        i_rx_data  <= ~v;
        @(posedge i_ref_clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(rxf_pkg::OFS_IOCFG);
        `CHECK("sel", 32'h6, d)
        `CHECK("gso", 1'b0, o_general_status_output)
        rd(rxf_pkg::OFS_PLEN);
        `CHECK("plen", 32'hff, d)
        rd(8'h1c);
        `CHECK("resp", rxf_pkg::RESP_SLVERR, r)
        `CHECK("rdata", 32'h0, d)
        $display("test reset done");
    endtask
    task automatic t_config();
        rxf_host_model_inst.set_length(1'b1);
        rd(rxf_pkg::OFS_PLEN);
        `CHECK("plen", 32'h3d, d)
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b1, 2'h0, 1'b0, 7'h00), d)
        rxf_host_model_inst.set_length(1'b0);
        rd(rxf_pkg::OFS_PLEN);
        `CHECK("plen", 32'h3e, d)
        wr(rxf_pkg::OFS_PCTL2ND, 32'h4);
        wr(rxf_pkg::OFS_PCTL1ST, 32'h5);
        rd(rxf_pkg::OFS_PCTL1ST);
        `CHECK("pctl1st", 32'h5, d)
        rd(rxf_pkg::OFS_PCTL2ND);
        `CHECK("pctl2nd", 32'h4, d)
        wr(rxf_pkg::OFS_PCTL1ST, 32'h4);
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b0, 2'h0, 1'b0, 7'h00), d)
        $display("test config done");
    endtask
    task automatic t_overflow();
        int i;
        wr(rxf_pkg::OFS_CMD, 32'h1 << rxf_pkg::CMD_RX);
        for (i = 0; i < 64; i++) send(8'(i));
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b0, 2'h1, 1'b0, 7'h40), d)
        `CHECK("gso", 1'b1, o_general_status_output)
        send(8'h40);
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b0, 2'h1, 1'b1, 7'h40), d)
        send(8'h41);
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b0, 2'h2, 1'b1, 7'h40), d)
        `CHECK("gso", 1'b0, o_general_status_output)
        wr(rxf_pkg::OFS_CMD, 32'h1 << rxf_pkg::CMD_FLUSH);
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b0, 2'h2, 1'b1, 7'h40), d)
        rxf_host_model_inst.recover();
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b0, 2'h0, 1'b0, 7'h00), d)
        rd(rxf_pkg::OFS_DATA);
        `CHECK("data", 32'h0, d)
        $display("test overflow done");
    endtask
    task automatic t_drain();
        int i;
        wr(rxf_pkg::OFS_CMD, 32'h1 << rxf_pkg::CMD_RX);
        // Longer than the storage, drained byte by byte
        for (i = 0; i < 70; i++) begin
            send(8'(i + 8'h80));
            rxf_host_model_inst.drain_one(b);
            `CHECK("byte", 8'(i + 8'h80), b)
        end
        rd(rxf_pkg::OFS_STATUS);
        `CHECK("status", st_word(1'b0, 2'h1, 1'b0, 7'h00), d)
        wr(rxf_pkg::OFS_IOCFG, 32'h1);
        send(8'h11);
        repeat (2) @(posedge i_ref_clk);
        `CHECK("gso", 1'b1, o_general_status_output)
        rxf_host_model_inst.drain_one(b);
        repeat (2) @(posedge i_ref_clk);
        `CHECK("gso", 1'b0, o_general_status_output)
        $display("test drain done");
    endtask
    task automatic t_bus();
        wr(8'h1c, 32'h1);
        `CHECK("bresp", rxf_pkg::RESP_SLVERR, r)
        wr(rxf_pkg::OFS_STATUS, 32'hfff);
        `CHECK("bresp", rxf_pkg::RESP_OKAY, r)
        // Low byte strobe clear: accepted, but nothing is stored
        rxf_host_model_inst.strb_sel = 4'he;
        wr(rxf_pkg::OFS_PLEN, 32'h3d);
        rxf_host_model_inst.strb_sel = 4'hf;
        `CHECK("bresp", rxf_pkg::RESP_OKAY, r)
        rxf_host_model_inst.late_ready = 1'b1;
        wr(rxf_pkg::OFS_CMD, 32'h1 << rxf_pkg::CMD_IDLE);
        rd(rxf_pkg::OFS_STATUS);
        rxf_host_model_inst.late_ready = 1'b0;
        `CHECK("rresp", rxf_pkg::RESP_OKAY, r)
        `CHECK("status", st_word(1'b0, 2'h0, 1'b0, 7'h00), d)
        rd(rxf_pkg::OFS_PLEN);
        `CHECK("plen", 32'h3e, d)
        $display("test bus done");
    endtask
    // ==========================================================
    // Verdict
    task automatic finish_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic timeout_hit();
        failures++;
        finish_test();
    endtask
    initial begin
        i_sys_rst  = 1'b1;
        i_rx_valid = 1'b0;
        i_rx_data  = 8'h00;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_config();
        t_overflow();
        t_drain();
        t_bus();
        finish_test();
    end
endmodule
